// ### core/xfer_decode_consts.svh
/*
 constants of the transfer type decoder: register offsets, field
 positions, reset values and code patterns. assumes it is included
 by its bare name from a file that also sees the package.
*/
`ifndef XFER_DECODE_CONSTS_SVH
`define XFER_DECODE_CONSTS_SVH
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_LAST        8'h08
`define OFS_COUNT       8'h0c
`define CTRL_LEGACY_BIT 0
`define CTRL_RESET      32'h0000_0000
`define TT_ATOMIC_BIT   4
`define TT_DIR_BIT      3
`define TT_BURST_BIT    2
`define TT_TAIL_HI      1
`define TT_TAIL_LO      0
`define TT_TAIL_OK      2'h2
`define TT_RWITM        5'h0e
`define TT_RESERVED     5'h16
`define STRAP_100       2'h1
`define STRAP_133       2'h3
`endif

// ### core/xfer_decode_pkg.sv
/*
 types of the transfer type decoder. assumes nothing outside.
*/
package xfer_decode_pkg;
   typedef enum logic [1:0] {
      FREQ_UNKNOWN = 2'h0,
      FREQ_100     = 2'h1,
      FREQ_133     = 2'h2
   } bus_freq_t;

   typedef struct packed {
      logic valid;
      logic read;
      logic burst;
      logic atomic;
      logic rwitm;
      logic bad;
   } xfer_class_t;
endpackage

// ### core/xfer_decode.sv
/*
 transfer type decoder of the processor to host bus bridge, with apb
 registers. assumes one 100 MHz clock, synchronous active-low reset,
 and inputs synchronous to clk. a transfer is one cycle of xfer_start.
*/
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "xfer_decode_consts.svh"
module xfer_decode (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output var  logic [31:0]                 prdata,
   output var  logic                        pready,
   output var  logic                        pslverr,
   // processor transfer start
   input  wire logic                        xfer_start,
   input  wire logic [4:0]                  transfer_type_code,
   // host side request
   input  wire logic                        host_done,
   output var  xfer_decode_pkg::xfer_class_t host_req,
   output var  logic                        host_lock_n,
   // interrupts and straps
   input  wire logic                        system_management_irq_n,
   input  wire logic                        local_irq_line_zero,
   input  wire logic                        local_irq_line_one,
   input  wire logic [1:0]                  bus_frequency_strap,
   output var  logic                        machine_check_in_n,
   output var  logic                        cpu_int_n,
   output var  logic                        cpu_nmi,
   output var  logic [1:0]                  lapic_lines
);
   logic                         legacy_r;
   logic                         strap_taken_r;
   xfer_decode_pkg::bus_freq_t   freq_r;
   logic [4:0]                   last_r;
   logic [15:0]                  count_r;
   logic                         busy_r;
   xfer_decode_pkg::xfer_class_t cls;
   logic                         acc;
   logic                         wr;

   assign acc = psel && penable;
   assign wr  = acc && pwrite;

   always_comb begin
      cls        = '0;
      cls.valid  = xfer_start;
      cls.read   = transfer_type_code[`TT_DIR_BIT];
      cls.burst  = transfer_type_code[`TT_BURST_BIT];
      cls.atomic = transfer_type_code[`TT_ATOMIC_BIT];
      cls.rwitm  = (transfer_type_code == `TT_RWITM);
      // unsupported codes, external control word among them, flagged
      cls.bad    = (transfer_type_code == `TT_RESERVED) ||
                   (transfer_type_code[`TT_TAIL_HI:`TT_TAIL_LO]
                    != `TT_TAIL_OK);
   end

   // apb: zero wait states, unmapped offsets answer with an error
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         legacy_r <= 1'b0;
      end else if (wr && paddr == `OFS_CTRL) begin
         legacy_r <= pwdata[`CTRL_LEGACY_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               `OFS_CTRL:   prdata <= {31'h0, legacy_r};
               `OFS_STATUS: prdata <= {28'h0, busy_r, strap_taken_r,
                                       freq_r};
               `OFS_LAST:   prdata <= {27'h0, last_r};
               `OFS_COUNT:  prdata <= {16'h0, count_r};
               default:     pslverr <= 1'b1;
            endcase
         end
      end
   end

   // strap caught once after reset release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strap_taken_r <= 1'b0;
         freq_r        <= xfer_decode_pkg::FREQ_UNKNOWN;
      end else if (!strap_taken_r) begin
         strap_taken_r <= 1'b1;
         case (bus_frequency_strap)
            `STRAP_100: freq_r <= xfer_decode_pkg::FREQ_100;
            `STRAP_133: freq_r <= xfer_decode_pkg::FREQ_133;
            default:    freq_r <= xfer_decode_pkg::FREQ_UNKNOWN;
         endcase
      end
   end

   // host request of a good code and its lock held until host_done
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         host_req    <= '0;
         host_lock_n <= 1'b1;
         busy_r      <= 1'b0;
         last_r      <= 5'h00;
         count_r     <= 16'h0000;
      end else if (busy_r) begin
         if (host_done) begin
            busy_r      <= 1'b0;
            host_req    <= '0;
            host_lock_n <= 1'b1;
         end
      end else if (xfer_start) begin
         host_req    <= cls;
         busy_r      <= !cls.bad;
         host_lock_n <= !(cls.atomic && !cls.bad);
         last_r      <= transfer_type_code;
         count_r     <= count_r + 16'h0001;
      end else begin
         host_req <= '0;
      end
   end

   // interrupt routing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         machine_check_in_n <= 1'b1;
         cpu_int_n          <= 1'b1;
         cpu_nmi            <= 1'b0;
         lapic_lines        <= 2'h0;
      end else begin
         machine_check_in_n <= system_management_irq_n;
         cpu_int_n   <= !(legacy_r && local_irq_line_zero);
         cpu_nmi     <= legacy_r && local_irq_line_one;
         lapic_lines <= legacy_r ? 2'h0 :
                        {local_irq_line_one, local_irq_line_zero};
      end
   end

   // host lock, held for the whole host transaction
   lock_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (xfer_start && !busy_r && transfer_type_code[`TT_ATOMIC_BIT] &&
       transfer_type_code[`TT_TAIL_HI:`TT_TAIL_LO] == `TT_TAIL_OK &&
       transfer_type_code != `TT_RESERVED) |=> !host_lock_n && busy_r)
      else $error("lock not taken on atomic transfer");
   lock_stay_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (busy_r && !host_lock_n && !host_done) |=> !host_lock_n && busy_r)
      else $error("lock dropped before host done");
   lock_release_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (busy_r && host_done) |=> host_lock_n && !busy_r)
      else $error("lock not released at host done");
   lock_normal_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (xfer_start && !busy_r && !transfer_type_code[`TT_ATOMIC_BIT])
      |=> host_lock_n)
      else $error("lock taken on normal transfer");
   reserved_code_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (xfer_start && !busy_r && transfer_type_code == `TT_RESERVED)
      |=> host_req.bad && host_lock_n && !busy_r)
      else $error("reserved code not refused");
   req_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (busy_r && !host_done) |=> $stable(host_req) && busy_r)
      else $error("host request not held");

   // transfer classification
   dir_flag_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (xfer_start && !busy_r) |=> host_req.read ==
      $past(transfer_type_code[`TT_DIR_BIT]))
      else $error("direction wrong");
   rwitm_code_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (xfer_start && !busy_r && transfer_type_code == `TT_RWITM)
      |=> host_req.rwitm && host_req.read && host_req.burst)
      else $error("burst read not line read");
   rwitm_only_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (xfer_start && !busy_r && transfer_type_code != `TT_RWITM)
      |=> !host_req.rwitm)
      else $error("line read flagged on other code");

   // interrupt routing
   smi_route_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> machine_check_in_n == $past(system_management_irq_n))
      else $error("smi not routed");
   intr_mode_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (legacy_r && local_irq_line_zero)
      |=> !cpu_int_n && !lapic_lines[0])
      else $error("line zero mode wrong");
   intr_ctrl_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!legacy_r && local_irq_line_zero)
      |=> cpu_int_n && lapic_lines[0])
      else $error("line zero controller mode wrong");
   nmi_mode_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!legacy_r && local_irq_line_one)
      |=> !cpu_nmi && lapic_lines[1])
      else $error("line one mode wrong");
   nmi_legacy_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (legacy_r && local_irq_line_one)
      |=> cpu_nmi && !lapic_lines[1])
      else $error("line one nmi mode wrong");

   // strap capture
   strap_map_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!strap_taken_r && bus_frequency_strap == `STRAP_133)
      |=> freq_r == xfer_decode_pkg::FREQ_133)
      else $error("strap decode wrong");
   strap_100_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!strap_taken_r && bus_frequency_strap == `STRAP_100)
      |=> freq_r == xfer_decode_pkg::FREQ_100)
      else $error("strap slow decode wrong");
   strap_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      strap_taken_r |=> $stable(freq_r) && strap_taken_r)
      else $error("strap value changed after capture");
endmodule // xfer_decode
`default_nettype wire

// ### sim/host_side_model.sv
/*
 host chipset side: ends each accepted host request after a number of
 wait cycles. assumes requests are held until done is seen.
*/
`timescale 1ns/10ps
`default_nettype none
module host_side_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // host request and answer
   input  wire logic       req_valid,
   input  wire logic [3:0] wait_cycles,
   output var  logic       done
);
   logic [3:0] cnt_r;
   // done is a one-cycle pulse; the request then drops
   always_ff @(posedge clk) begin
      if (!rst_n || !req_valid || done) begin
         cnt_r <= 4'h0;
         done  <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
         done  <= (cnt_r == wait_cycles);
      end
   end
endmodule // host_side_model
`default_nettype wire

// ### sim/cpu_transfer_type_decoder_tb.sv
/*
 bench of the transfer type decoder. assumes the core files and the
 host side model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu_transfer_type_decoder_tb;
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, start = 0, done, smi_n = 1;
   logic        lz = 0, lo = 0, mc_n, int_n, nmi, lock_n;
   logic [1:0]  strap = 2'h1, lapic;
   logic [4:0]  code = 5'h02;
   logic [3:0]  dly = 4'h1;
   xfer_decode_pkg::xfer_class_t req;
   int          n_errors = 0, checks = 0;
   always #5 clk = ~clk;
   xfer_decode DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .xfer_start(start), .transfer_type_code(code), .host_done(done),
      .host_req(req), .host_lock_n(lock_n),
      .system_management_irq_n(smi_n), .local_irq_line_zero(lz),
      .local_irq_line_one(lo), .bus_frequency_strap(strap),
      .machine_check_in_n(mc_n), .cpu_int_n(int_n), .cpu_nmi(nmi),
      .lapic_lines(lapic));
   host_side_model HOST (.clk(clk), .rst_n(rst_n),
      .req_valid(req.valid & ~req.bad), .wait_cycles(dly), .done(done));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: no pready", $time);
         complete_run;
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic tick;
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic do_reset(input logic [1:0] s, input logic [31:0] st);
      @(posedge clk);
      {rst_n, strap} <= {1'b0, s};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, st);
      chk({req, lock_n, mc_n}, 8'h03);
   endtask
   task automatic xfer(input logic [4:0] c);
      logic bad;
      int   i;
      bad = (c[1:0] != 2'b10) || (c == 5'h16);
      @(posedge clk);
      {start, code} <= {1'b1, c};
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      if (bad) chk(req.bad, 1'b1);
      else chk(req, {1'b1, c[3], c[2], c[4], c == 5'h0e, 1'b0});
      chk(lock_n, !(c[4] && !bad));
      for (i = 0; i < 40 && !bad && done !== 1'b1; i++) @(negedge clk);
      if (!bad && done !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: host done never came", $time);
         complete_run;
      end
      chk(lock_n, !(c[4] && !bad));
      tick();
      chk({req, lock_n}, 7'h01);
      tick();
   endtask
   task automatic irq_routing;
      @(posedge clk);
      {smi_n, lz, lo} <= 3'b010;
      tick();
      chk({mc_n, lapic, int_n, nmi}, 5'b00110);
      @(posedge clk);
      {smi_n, lz, lo} <= 3'b101;
      tick();
      chk({mc_n, lapic, int_n, nmi}, 5'b11010);
      apb(1'b1, 8'h00, 32'h1);
      @(posedge clk);
      {lz, lo} <= 2'b11;
      tick();
      chk({int_n, nmi, lapic}, 4'b0100);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
   endtask
   initial begin
      do_reset(2'h3, 32'h6);
      do_reset(2'h1, 32'h5);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      xfer(5'h02);
      dly <= 4'h6;
      xfer(5'h0a);
      xfer(5'h0e);
      xfer(5'h06);
      xfer(5'h12);
      dly <= 4'h0;
      xfer(5'h1a);
      xfer(5'h1e);
      xfer(5'h16);
      xfer(5'h03);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h9);
      irq_routing;
      complete_run;
   end
endmodule // cpu_transfer_type_decoder_tb
`default_nettype wire
